//--- core/scl_defines.vh
// constants of the serial command line parser
`ifndef SCL_DEFINES_VH
`define SCL_DEFINES_VH
// received control, punctuation, digit and letter characters, and the case bit
`define SCL_CH_CTRLC 8'h03
`define SCL_CH_CTRLP 8'h10
`define SCL_CH_CTRLT 8'h14
`define SCL_CH_BS 8'h08
`define SCL_CH_ESC 8'h1B
`define SCL_CH_CR 8'h0D
`define SCL_CH_LF 8'h0A
`define SCL_CH_SP 8'h20
`define SCL_CH_QUOTE 8'h22
`define SCL_CH_HELP 8'h3F
`define SCL_CH_PLUS 8'h2B
`define SCL_CH_MINUS 8'h2D
`define SCL_CH_DOT 8'h2E
`define SCL_CH_ZERO 8'h30
`define SCL_CH_NINE 8'h39
`define SCL_CH_X 8'h78
`define SCL_CH_UA 8'h41
`define SCL_CH_UF 8'h46
`define SCL_CH_UZ 8'h5A
`define SCL_CH_LA 8'h61
`define SCL_CH_LZ 8'h7A
`define SCL_CH_UC 8'h43
`define SCL_CH_UD 8'h44
`define SCL_CH_UL 8'h4C
`define SCL_CH_UN 8'h4E
`define SCL_CH_UO 8'h4F
`define SCL_CH_UT 8'h54
`define SCL_CH_UV 8'h56
`define SCL_CH_UW 8'h57
`define SCL_CH_TILDE 8'h7E
`define SCL_CASE_BIT 8'h20
// line buffer and token limits
`define SCL_LINE_MAX 6'd32
`define SCL_KW_MAX 4'd8
`define SCL_ID_MAX 6'd4
// command type codes
`define SCL_TY_NONE 3'd0
`define SCL_TY_CAL 3'd1
`define SCL_TY_DIAG 3'd2
`define SCL_TY_LOGON 3'd3
`define SCL_TY_TEST 3'd4
`define SCL_TY_VAR 3'd5
`define SCL_TY_WARN 3'd6
`define SCL_TY_HELP 3'd7
// argument format bits
`define SCL_FMT_INT 0
`define SCL_FMT_HEX 1
`define SCL_FMT_FLT 2
`define SCL_FMT_BOOL 3
`define SCL_FMT_STR 4
// parse phases
`define SCL_FLD_TYPE 2'd0
`define SCL_FLD_IDKW 2'd1
`define SCL_FLD_ARG 2'd2
`endif

//--- core/scl_parser.v
// serial command line parser: line editing, modes, tokenising and argument checks
// How it works
// - control-T selects echoing, editable terminal mode; echo needs both mode flags clear
// - control-C outside a listing selects silent, non-editing computer mode
// - lines end with carriage return; nothing is executed before it
// - backspace in editing mode removes the last buffered character
// - escape in editing mode empties the whole line buffer
// - question mark, optional ID, return starts the full command listing
// - ID optional alone on a line, required and matched on multidrop
// - control-C during the listing pauses it instead of changing mode
// - control-P after a pause resumes the listing where it stopped
// - letters and keywords are matched regardless of case; the x of the 0x prefix must be lowercase
// - line is type letter, optional ID, keyword, arguments, return
// - type letters C, D, L, T, V, W decode to six command types
// - integer is optional sign plus at least one decimal digit
// - hexadecimal is 0x plus hex digits, never signed
// - float is optional sign, digits, optional point, one digit minimum, no exponent
// - boolean is exactly ON or OFF
// - text is quoted printable characters, spaces allowed, no inner quote
// - names must be complete; keyword reported whole with its length
// - every transmitted line ends with carriage return then line feed
// - instrument ID is one to four decimal digits; a leading sign is also accepted and counts toward the four
`include "scl_defines.vh"
module scl_parser (
  input wire mclk,
  input wire rst,
  input wire [7:0] rxData,
  input wire rxValid,
  input wire [1:0] quietFlags,
  input wire multiDrop,
  input wire [13:0] myId,
  input wire listDone,
  output reg termMode_ff,
  output reg listRun_ff,
  output reg listPaused_ff,
  output reg [7:0] txData_ff,
  output reg txValid_ff,
  output reg busy_ff,
  output reg cmdValid_ff,
  output reg syntaxErr_ff,
  output reg [2:0] cmdType_ff,
  output reg idGiven_ff,
  output reg [13:0] cmdId_ff,
  output reg [63:0] keyword_ff,
  output reg [3:0] kwLen_ff,
  output reg [3:0] argCount_ff,
  output reg [4:0] argFmt_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // character helpers
  function [7:0] upc;
    input [7:0] c;
    begin
      upc = (c >= `SCL_CH_LA && c <= `SCL_CH_LZ) ? (c & ~`SCL_CASE_BIT) : c;
    end
  endfunction

  function isDig;
    input [7:0] c;
    begin
      isDig = (c >= `SCL_CH_ZERO) && (c <= `SCL_CH_NINE);
    end
  endfunction

  function isHexDig;
    input [7:0] c;
    begin
      isHexDig = isDig(c) || (upc(c) >= `SCL_CH_UA && upc(c) <= `SCL_CH_UF);
    end
  endfunction

  // six documented type letters, question mark for help
  function [2:0] typeOf;
    input [7:0] c;
    begin
      case (upc(c))
        `SCL_CH_UC: typeOf = `SCL_TY_CAL;
        `SCL_CH_UD: typeOf = `SCL_TY_DIAG;
        `SCL_CH_UL: typeOf = `SCL_TY_LOGON;
        `SCL_CH_UT: typeOf = `SCL_TY_TEST;
        `SCL_CH_UV: typeOf = `SCL_TY_VAR;
        `SCL_CH_UW: typeOf = `SCL_TY_WARN;
        `SCL_CH_HELP: typeOf = `SCL_TY_HELP;
        default: typeOf = `SCL_TY_NONE;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state and storage
  localparam ST_COLLECT = 2'd0;
  localparam ST_SCAN = 2'd1;
  localparam ST_FINISH = 2'd2;

  reg [1:0] state_ff;
  reg [7:0] lineBuf [0:31];
  reg [5:0] lineLen_ff;
  reg overflow_ff;
  reg lfPend_ff;
  reg [5:0] scanIdx_ff;
  reg [1:0] fld_ff;
  reg [5:0] tokLen_ff;
  reg digSeen_ff, other_ff, signBad_ff, hex_ff, on_ff, off_ff;
  reg [1:0] dots_ff;
  reg qOpen_ff, qClosed_ff, strOk_ff;
  reg err_ff;
  reg [13:0] idAcc_ff;
  reg [63:0] kwAcc_ff;
  integer i;

  wire echoOn = termMode_ff && (quietFlags == 2'b00);
  wire printable = (rxData >= `SCL_CH_SP) && (rxData <= `SCL_CH_TILDE);
  wire listing = listRun_ff || listPaused_ff;

  ////////////////////////////////////////////////////////////////////////////
  // scan view of the current character and token classification
  wire atEnd = (scanIdx_ff == lineLen_ff);
  wire [7:0] ch = atEnd ? `SCL_CH_SP : lineBuf[scanIdx_ff[4:0]];
  wire delim = atEnd || (ch == `SCL_CH_SP && !qOpen_ff);
  wire isSign = (ch == `SCL_CH_PLUS) || (ch == `SCL_CH_MINUS);
  wire fInt = digSeen_ff && !other_ff && !signBad_ff && dots_ff == 2'd0;
  wire fHex = hex_ff && tokLen_ff >= 6'd3;
  wire fFlt = digSeen_ff && !other_ff && !signBad_ff && dots_ff <= 2'd1;
  wire fBool = (on_ff && tokLen_ff == 6'd2) || (off_ff && tokLen_ff == 6'd3);
  wire fStr = strOk_ff && qClosed_ff && tokLen_ff >= 6'd3;
  wire [4:0] fmt = {fStr, fBool, fFlt, fHex, fInt};
  wire isSignTok = signBad_ff || (dots_ff != 2'd0);
  wire idTok = digSeen_ff && !other_ff && !isSignTok && tokLen_ff <= `SCL_ID_MAX;
  wire [2:0] ty = typeOf(lineBuf[0]);

  ////////////////////////////////////////////////////////////////////////////
  // receive side: modes, listing control, editing and echo
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_COLLECT;
      termMode_ff <= 1'b0;
      listRun_ff <= 1'b0;
      listPaused_ff <= 1'b0;
      txData_ff <= 8'h00;
      txValid_ff <= 1'b0;
      lfPend_ff <= 1'b0;
      lineLen_ff <= 6'd0;
      overflow_ff <= 1'b0;
      busy_ff <= 1'b0;
      scanIdx_ff <= 6'd0;
      fld_ff <= `SCL_FLD_TYPE;
      tokLen_ff <= 6'd0;
      digSeen_ff <= 1'b0;
      other_ff <= 1'b0;
      signBad_ff <= 1'b0;
      hex_ff <= 1'b0;
      on_ff <= 1'b0;
      off_ff <= 1'b0;
      dots_ff <= 2'd0;
      qOpen_ff <= 1'b0;
      qClosed_ff <= 1'b0;
      strOk_ff <= 1'b0;
      err_ff <= 1'b0;
      idAcc_ff <= 14'h0000;
      kwAcc_ff <= 64'h0000_0000_0000_0000;
      cmdValid_ff <= 1'b0;
      syntaxErr_ff <= 1'b0;
      cmdType_ff <= `SCL_TY_NONE;
      idGiven_ff <= 1'b0;
      cmdId_ff <= 14'h0000;
      keyword_ff <= 64'h0000_0000_0000_0000;
      kwLen_ff <= 4'd0;
      argCount_ff <= 4'd0;
      argFmt_ff <= 5'h00;
      for (i = 0; i < 32; i = i + 1) begin
        lineBuf[i] <= 8'h00;
      end
    end else begin
      txValid_ff <= 1'b0;
      cmdValid_ff <= 1'b0;
      syntaxErr_ff <= 1'b0;
      // line feed follows every echoed carriage return
      if (lfPend_ff) begin
        txData_ff <= `SCL_CH_LF;
        txValid_ff <= 1'b1;
        lfPend_ff <= 1'b0;
      end
      // listing engine reports the end of the listing
      if (listDone) begin
        listRun_ff <= 1'b0;
        listPaused_ff <= 1'b0;
      end
      // control characters act at once, even while a line is scanned
      if (rxValid && rxData == `SCL_CH_CTRLT) begin
        termMode_ff <= 1'b1;
      end else if (rxValid && rxData == `SCL_CH_CTRLC) begin
        if (listing) begin
          listRun_ff <= 1'b0;
          listPaused_ff <= 1'b1;
        end else begin
          termMode_ff <= 1'b0;
        end
      end else if (rxValid && rxData == `SCL_CH_CTRLP && listPaused_ff && !listDone) begin
        listPaused_ff <= 1'b0;
        listRun_ff <= 1'b1;
      end
      case (state_ff)
        ST_COLLECT: begin
          if (rxValid && rxData == `SCL_CH_CR) begin
            state_ff <= ST_SCAN;
            busy_ff <= 1'b1;
            scanIdx_ff <= 6'd0;
            fld_ff <= `SCL_FLD_TYPE;
            tokLen_ff <= 6'd0;
            err_ff <= overflow_ff;
            qOpen_ff <= 1'b0; // stale open quote would swallow a leading space
            idGiven_ff <= 1'b0;
            kwLen_ff <= 4'd0;
            argCount_ff <= 4'd0;
            argFmt_ff <= 5'h00;
            cmdType_ff <= `SCL_TY_NONE;
            if (echoOn) begin
              txData_ff <= `SCL_CH_CR;
              txValid_ff <= 1'b1;
              lfPend_ff <= 1'b1;
            end
          end else if (rxValid && rxData == `SCL_CH_BS && echoOn) begin
            if (lineLen_ff != 6'd0) begin
              lineLen_ff <= lineLen_ff - 6'd1;
              txData_ff <= `SCL_CH_BS;
              txValid_ff <= 1'b1;
            end
          end else if (rxValid && rxData == `SCL_CH_ESC && echoOn) begin
            lineLen_ff <= 6'd0;
            overflow_ff <= 1'b0;
          end else if (rxValid && printable) begin
            // a full buffer drops the char but poisons the line
            if (lineLen_ff == `SCL_LINE_MAX) begin
              overflow_ff <= 1'b1;
            end else begin
              lineBuf[lineLen_ff[4:0]] <= rxData;
              lineLen_ff <= lineLen_ff + 6'd1;
            end
            if (echoOn) begin
              txData_ff <= rxData;
              txValid_ff <= 1'b1;
            end
          end
        end
        ST_SCAN: begin
          scanIdx_ff <= scanIdx_ff + 6'd1;
          if (delim) begin
            // token end; runs of spaces give empty tokens, skipped
            if (tokLen_ff != 6'd0) begin
              case (fld_ff)
                `SCL_FLD_TYPE: begin
                  cmdType_ff <= ty;
                  fld_ff <= `SCL_FLD_IDKW;
                  if (tokLen_ff != 6'd1 || ty == `SCL_TY_NONE) begin
                    err_ff <= 1'b1;
                  end
                end
                `SCL_FLD_IDKW: begin
                  if (idTok && !idGiven_ff) begin
                    idGiven_ff <= 1'b1;
                    cmdId_ff <= idAcc_ff;
                  end else if (other_ff && tokLen_ff <= {2'b00, `SCL_KW_MAX}) begin
                    keyword_ff <= kwAcc_ff;
                    kwLen_ff <= tokLen_ff[3:0];
                    fld_ff <= `SCL_FLD_ARG;
                  end else begin
                    err_ff <= 1'b1;
                  end
                end
                default: begin
                  argFmt_ff <= fmt;
                  argCount_ff <= argCount_ff + 4'd1;
                  if (fmt == 5'h00) begin
                    err_ff <= 1'b1;
                  end
                end
              endcase
            end
            tokLen_ff <= 6'd0;
            if (atEnd) begin
              state_ff <= ST_FINISH;
            end
          end else begin
            // per character token checks
            tokLen_ff <= tokLen_ff + 6'd1;
            if (tokLen_ff == 6'd0) begin
              digSeen_ff <= isDig(ch);
              other_ff <= !(isDig(ch) || isSign || ch == `SCL_CH_DOT);
              signBad_ff <= 1'b0;
              dots_ff <= (ch == `SCL_CH_DOT) ? 2'd1 : 2'd0;
              hex_ff <= (ch == `SCL_CH_ZERO);
              on_ff <= (upc(ch) == `SCL_CH_UO);
              off_ff <= (upc(ch) == `SCL_CH_UO);
              qOpen_ff <= (ch == `SCL_CH_QUOTE);
              strOk_ff <= (ch == `SCL_CH_QUOTE);
              qClosed_ff <= 1'b0;
              idAcc_ff <= isDig(ch) ? {10'd0, ch[3:0]} : 14'h0000;
              kwAcc_ff <= {56'd0, upc(ch)};
            end else begin
              digSeen_ff <= digSeen_ff || isDig(ch);
              if (!(isDig(ch) || isSign || ch == `SCL_CH_DOT)) begin
                other_ff <= 1'b1;
              end
              if (isSign) begin
                signBad_ff <= 1'b1;
              end
              if (ch == `SCL_CH_DOT && dots_ff != 2'd2) begin
                dots_ff <= dots_ff + 2'd1;
              end
              if (tokLen_ff == 6'd1) begin
                hex_ff <= hex_ff && (ch == `SCL_CH_X);
              end else begin
                hex_ff <= hex_ff && isHexDig(ch);
              end
              on_ff <= on_ff && tokLen_ff == 6'd1 && upc(ch) == `SCL_CH_UN;
              off_ff <= off_ff && tokLen_ff <= 6'd2 && upc(ch) == `SCL_CH_UF;
              if (qOpen_ff && ch == `SCL_CH_QUOTE) begin
                qOpen_ff <= 1'b0;
                qClosed_ff <= 1'b1;
              end else if (qClosed_ff) begin
                strOk_ff <= 1'b0;
              end
              // id fits 14 bits: at most four digits are accepted
              idAcc_ff <= (idAcc_ff * 14'd10) + {10'd0, ch[3:0]};
              if (tokLen_ff < {2'b00, `SCL_KW_MAX}) begin
                kwAcc_ff <= {kwAcc_ff[55:0], upc(ch)};
              end
            end
          end
        end
        ST_FINISH: begin
          state_ff <= ST_COLLECT;
          busy_ff <= 1'b0;
          lineLen_ff <= 6'd0;
          overflow_ff <= 1'b0;
          if (lineLen_ff == 6'd0 && !err_ff) begin
            // empty line: nothing to do
          end else if (err_ff || qOpen_ff ||
                       (cmdType_ff != `SCL_TY_HELP && fld_ff != `SCL_FLD_ARG) ||
                       (cmdType_ff == `SCL_TY_HELP && fld_ff == `SCL_FLD_ARG)) begin
            syntaxErr_ff <= 1'b1;
          end else if (multiDrop && (!idGiven_ff || cmdId_ff != myId)) begin
            // not addressed to this instrument on a shared line
            cmdType_ff <= cmdType_ff;
          end else if (cmdType_ff == `SCL_TY_HELP) begin
            listRun_ff <= 1'b1;
            listPaused_ff <= 1'b0;
          end else begin
            cmdValid_ff <= 1'b1;
          end
        end
        default: begin
          state_ff <= ST_COLLECT;
        end
      endcase
    end
  end

endmodule // scl_parser

//--- verif/scl_parser_sva.sv
// assertion checker for the command line parser ports
module scl_parser_sva (
  input wire mclk,
  input wire rst,
  input wire [7:0] rxData,
  input wire rxValid,
  input wire [1:0] quietFlags,
  input wire multiDrop,
  input wire [13:0] myId,
  input wire listDone,
  input wire termMode_ff,
  input wire listRun_ff,
  input wire listPaused_ff,
  input wire [7:0] txData_ff,
  input wire txValid_ff,
  input wire busy_ff,
  input wire cmdValid_ff,
  input wire syntaxErr_ff,
  input wire [2:0] cmdType_ff,
  input wire idGiven_ff,
  input wire [13:0] cmdId_ff,
  input wire [63:0] keyword_ff,
  input wire [3:0] kwLen_ff,
  input wire [3:0] argCount_ff,
  input wire [4:0] argFmt_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////
  // one clock domain, so clock and reset are shared
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  property p_termEnter;
    rxValid && rxData == 8'h14 |=> termMode_ff;
  endproperty
  a_termEnter: assert property (p_termEnter)
    else $error("control-T did not select terminal mode");
  property p_echo;
    termMode_ff && quietFlags == 2'h0 && !busy_ff && rxValid && rxData inside {[8'h20:8'h7e]}
      |=> txValid_ff && txData_ff == $past(rxData);
  endproperty
  a_echo: assert property (p_echo)
    else $error("printable character not echoed");
  property p_compEnter;
    rxValid && rxData == 8'h03 && !listRun_ff && !listPaused_ff |=> !termMode_ff;
  endproperty
  a_compEnter: assert property (p_compEnter)
    else $error("control-C did not select computer mode");
  // compare data too, so a trailing line feed is not mistaken for an echo
  property p_noEcho;
    !termMode_ff && rxValid && rxData inside {[8'h20:8'h7e]}
      |=> !(txValid_ff && txData_ff == $past(rxData));
  endproperty
  a_noEcho: assert property (p_noEcho)
    else $error("echo seen in computer mode");
  property p_execAfterLine;
    cmdValid_ff || syntaxErr_ff |-> $past(busy_ff);
  endproperty
  a_execAfterLine: assert property (p_execAfterLine)
    else $error("line result without a scanned line");
  property p_pause;
    rxValid && rxData == 8'h03 && listRun_ff && !listDone
      |=> listPaused_ff && termMode_ff == $past(termMode_ff);
  endproperty
  a_pause: assert property (p_pause)
    else $error("control-C did not pause the listing");
  property p_resume;
    rxValid && rxData == 8'h10 && listPaused_ff && !listDone |=> listRun_ff && !listPaused_ff;
  endproperty
  a_resume: assert property (p_resume)
    else $error("control-P did not resume the listing");
  property p_crlf;
    txValid_ff && txData_ff == 8'h0d |=> txValid_ff && txData_ff == 8'h0a;
  endproperty
  a_crlf: assert property (p_crlf)
    else $error("return not followed by line feed");
  property p_kwLen;
    cmdValid_ff && cmdType_ff != 3'h7 |-> kwLen_ff inside {[4'h1:4'h8]};
  endproperty
  a_kwLen: assert property (p_kwLen)
    else $error("keyword length out of range");
  property p_idRange;
    cmdValid_ff && idGiven_ff |-> cmdId_ff <= 14'h270f;
  endproperty
  a_idRange: assert property (p_idRange)
    else $error("identifier above four digits");
  property p_oneResult;
    syntaxErr_ff |-> !cmdValid_ff ##1 !syntaxErr_ff;
  endproperty
  a_oneResult: assert property (p_oneResult)
    else $error("rejected line also executed");
endmodule // scl_parser_sva
bind scl_parser scl_parser_sva scl_parser_sva_inst (.*);

//--- verif/scl_host_model.sv
// host terminal model that types characters into the parser
module scl_host_model (
  input wire mclk,
  output logic [7:0] rxData,
  output logic rxValid
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////
  // idle at time zero
  initial begin
    rxData = 8'h00;
    rxValid = 1'b0;
  end
  // one character per take edge; data inverted after so stale bytes never look fresh
  task automatic send_byte(input logic [7:0] b);
    @(posedge mclk);
    rxData <= b;
    rxValid <= 1'b1;
    @(posedge mclk);
    rxValid <= 1'b0;
    rxData <= ~b;
  endtask
  // fields go out space-separated as written, always closed by return
  task automatic send_line(input string s);
    for (int i = 0; i < s.len(); i++) begin
      send_byte(s[i]);
    end
    send_byte(8'h0d);
  endtask
endmodule // scl_host_model

//--- verif/serial_command_line_parser_test.sv
// self-checking bench for the command line parser
module serial_command_line_parser_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, multiDrop, listDone, okSeen, errSeen, rxValid;
  logic termMode_ff, listRun_ff, listPaused_ff, txValid_ff, busy_ff;
  logic cmdValid_ff, syntaxErr_ff, idGiven_ff;
  logic [1:0] quietFlags;
  logic [13:0] myId, cmdId_ff;
  logic [7:0] rxData, txData_ff;
  logic [2:0] cmdType_ff;
  logic [63:0] keyword_ff;
  logic [3:0] kwLen_ff, argCount_ff;
  logic [4:0] argFmt_ff;
  int n_errors = 0;
  int cmp_count = 0;
  scl_parser scl_parser_inst (.*);
  scl_host_model scl_host_model_inst (.*);
  ////////////////////////////////////////////////////////////
  // 250 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input string name, input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // control characters act at once
  task automatic ctl(input logic [7:0] c);
    scl_host_model_inst.send_byte(c);
    @(negedge mclk);
  endtask
  // fixed window long enough for scan of any line used here
  task automatic run_line(input string s);
    okSeen = 1'b0;
    errSeen = 1'b0;
    scl_host_model_inst.send_line(s);
    @(negedge mclk);
    chk("busy", busy_ff, 1'b1);
    repeat (60) begin
      @(negedge mclk);
      if (cmdValid_ff === 1'b1) okSeen = 1'b1;
      if (syntaxErr_ff === 1'b1) errSeen = 1'b1;
    end
    chk("idle", busy_ff, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_modes;
    ctl(8'h14);
    chk("termMode", termMode_ff, 1'b1);
    scl_host_model_inst.send_byte(8'h7a);
    @(negedge mclk);
    chk("echoValid", txValid_ff, 1'b1);
    chk("echoData", txData_ff, 8'h7a);
    @(posedge mclk);
    quietFlags <= 2'h2;
    scl_host_model_inst.send_byte(8'h7a);
    @(negedge mclk);
    chk("quietEcho", txValid_ff, 1'b0);
    run_line("");
    chk("badType", errSeen, 1'b1);
    @(posedge mclk);
    quietFlags <= 2'h0;
    ctl(8'h03);
    chk("termMode", termMode_ff, 1'b0);
  endtask
  task automatic t_fields;
    run_line("v 12 kw 0x1f");
    chk("ok", okSeen, 1'b1);
    chk("cmdType", cmdType_ff, 3'h5);
    chk("idGiven", idGiven_ff, 1'b1);
    chk("cmdId", cmdId_ff, 14'h000c);
    chk("keyword", keyword_ff, 64'h0000_0000_0000_4b57);
    chk("kwLen", kwLen_ff, 4'h2);
    chk("argCount", argCount_ff, 4'h1);
    chk("argFmt", argFmt_ff, 5'h02);
  endtask
  task automatic t_types;
    string tl = "cDlTvW";
    for (int i = 0; i < 6; i++) begin
      run_line({tl.substr(i, i), " ab"});
      chk("typeOk", okSeen, 1'b1);
      chk("cmdType", cmdType_ff, 64'(i + 1));
    end
  endtask
  // bit 5 of the expectation marks a line that must be rejected
  task automatic t_formats;
    string fa[10] = '{"+12", "-1.5", ".5", "oFf", "\"a b\"", "0x1A", "1e5", "-0x1", "+", "\"ab"};
    logic [5:0] fe[10] = '{6'h05, 6'h04, 6'h04, 6'h08, 6'h10, 6'h02, 6'h20, 6'h20, 6'h20, 6'h20};
    for (int i = 0; i < 10; i++) begin
      run_line({"t ab ", fa[i]});
      chk("lineErr", errSeen, fe[i][5]);
      if (!fe[i][5]) chk("argFmt", argFmt_ff, fe[i][4:0]);
    end
  endtask
  task automatic t_edit;
    ctl(8'h14);
    run_line("zz q\033w ab\010c");
    chk("cmdType", cmdType_ff, 3'h6);
    chk("keyword", keyword_ff, 64'h0000_0000_0000_4143);
  endtask
  task automatic t_help;
    run_line("?");
    chk("listRun", listRun_ff, 1'b1);
    ctl(8'h03);
    chk("listPaused", listPaused_ff, 1'b1);
    chk("termMode", termMode_ff, 1'b1);
    ctl(8'h10);
    chk("listPaused", listPaused_ff, 1'b0);
    chk("listRun", listRun_ff, 1'b1);
    @(posedge mclk);
    listDone <= 1'b1;
    @(posedge mclk);
    listDone <= 1'b0;
    @(negedge mclk);
    chk("listEnd", listRun_ff, 1'b0);
  endtask
  task automatic t_multi;
    @(posedge mclk);
    multiDrop <= 1'b1;
    run_line("? 7");
    chk("otherId", listRun_ff, 1'b0);
    run_line("? 200");
    chk("ownHelp", listRun_ff, 1'b1);
    run_line("v ab");
    chk("noId", okSeen | errSeen, 1'b0);
    run_line("v 0200 ab");
    chk("ownId", okSeen, 1'b1);
    chk("cmdId", cmdId_ff, 14'h00c8);
    @(posedge mclk);
    multiDrop <= 1'b0;
    run_line("v 12345 ab");
    chk("longId", errSeen, 1'b1);
    run_line("x ab");
    chk("badType", errSeen, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'b1;
    quietFlags = 2'h0;
    multiDrop = 1'b0;
    myId = 14'h00c8;
    listDone = 1'b0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_modes;
    t_fields;
    t_types;
    t_formats;
    t_edit;
    t_help;
    t_multi;
    report_and_stop;
  end
  // a hang is cut short well after the expected 2000 cycles
  initial begin
    #100000;
    n_errors++;
    report_and_stop;
  end
endmodule // serial_command_line_parser_test
